//--- verif/boot_loader_properties.sv
// Purpose: temporal checks on the boot mode loader ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to the loader from the testbench top file
`timescale 1ns/100ps
module boot_loader_properties
	import boot_loader_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        reset,
	// mode pins
	input wire logic        mode_pin_a,
	input wire logic        mode_pin_b,
	input wire logic        mode_pin_c,
	input wire logic        mode_pin_d,
	// loader controls and results
	input wire logic        spi_loader_start,
	input wire logic        wd_disable,
	input wire logic        wd_clear,
	input wire logic        boot_done,
	input wire logic [31:0] entry_addr,
	input wire sci_cfg_t    sci_cfg,
	// parallel handshake
	input wire logic        device_ready_line,
	input wire logic        host_data_valid_line
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic [3:0] pins;
	assign pins = {mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d};

	flash_entry_a: assert property ($rose(boot_done) && mode_pin_a |-> entry_addr == FLASH_ENTRY)
		else $error("flash entry address wrong");
	spi_start_a: assert property (spi_loader_start |-> !mode_pin_a && mode_pin_b ##1 !spi_loader_start)
		else $error("serial memory start wrong");
	serial_start_a: assert property (sci_cfg.active |-> pins == 4'h3)
		else $error("serial loader in wrong mode");
	ram_entry_a: assert property ($rose(boot_done) && pins == 4'h2 |-> entry_addr == RAM_ENTRY)
		else $error("ram entry address wrong");
	otp_entry_a: assert property ($rose(boot_done) && pins == 4'h1 |-> entry_addr == OTP_ENTRY)
		else $error("otp entry address wrong");
	par_ready_a: assert property (!device_ready_line |-> pins == 4'h0)
		else $error("parallel ready outside parallel mode");
	wd_direct_a: assert property (wd_disable |-> !mode_pin_a && (mode_pin_b || (mode_pin_c ~^ mode_pin_d)))
		else $error("watchdog disabled in direct mode");
	wd_reenable_a: assert property ($fell(wd_disable) |-> wd_clear ##1 boot_done)
		else $error("watchdog not restored at loader end");
	port_setup_a: assert property (sci_cfg.active |-> sci_cfg.char_len == CHAR_LEN_8 && !sci_cfg.two_stop
		&& !sci_cfg.parity_en && sci_cfg.int_clk && !sci_cfg.loopback && !sci_cfg.rx_irq_en && !sci_cfg.tx_irq_en
		&& !sci_cfg.fifo_en && sci_cfg.low_speed_peripheral_clock_div == LOW_SPEED_PERIPHERAL_CLOCK_DIV4)
		else $error("serial port setup wrong");
	ready_first_a: assert property ($fell(device_ready_line) |-> host_data_valid_line)
		else $error("ready lowered while valid low");
	ready_ack_a: assert property (!device_ready_line && !host_data_valid_line |=> device_ready_line)
		else $error("no acknowledge after valid");
	ready_wait_a: assert property (device_ready_line && !host_data_valid_line |=> device_ready_line)
		else $error("ready lowered before valid released");
endmodule

//--- verif/boot_mode_select_loader_test.sv
// Purpose: self-checking bench of the boot mode select loader
// Assumes: apb with zero wait states, parallel host model
// Notes:   serial receive line idles high; serial lock and echo run after a mid-run reset
`timescale 1ns/100ps
module boot_mode_select_loader_test;
	import boot_loader_pkg::*;
	logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, spi_loader_entry, entry_addr;
	logic        mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d;
	logic        serial_receive_line, serial_transmit_line, host_data_valid_line, device_ready_line;
	logic        spi_loader_start, spi_loader_done, wd_disable, wd_clear, boot_done;
	logic [15:0] parallel_data;
	sci_cfg_t    sci_cfg;
	mem_wr_t     mem_wr;
	mem_wr_t     wr_q[$];
	int          failures, total_checks, clears, wd_on;
	logic [7:0]  echo;
	// slow lock rate, below 100 kbaud
	localparam int SER_BIT = 520;
	logic [15:0] bstream [17] = '{16'h08aa, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
		16'h003f, 16'h8000, 16'h0002, 16'h003f, 16'h9010, 16'h1234, 16'habcd, 16'h0000};
	logic [15:0] wstream [12] = '{16'h10aa, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
		16'h003d, 16'h1234, 16'h0000};
	logic [3:0]  dpins [3] = '{4'hf, 4'h2, 4'h1};
	logic [31:0] dent [3] = '{FLASH_ENTRY, RAM_ENTRY, OTP_ENTRY};

	boot_mode_select_loader #(.BIT_CNT_W(20)) dut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .mode_pin_c(mode_pin_c),
		.mode_pin_d(mode_pin_d), .serial_receive_line(serial_receive_line),
		.serial_transmit_line(serial_transmit_line), .sci_cfg(sci_cfg), .parallel_data(parallel_data),
		.host_data_valid_line(host_data_valid_line), .device_ready_line(device_ready_line),
		.spi_loader_start(spi_loader_start), .spi_loader_done(spi_loader_done),
		.spi_loader_entry(spi_loader_entry), .mem_wr(mem_wr), .wd_disable(wd_disable), .wd_clear(wd_clear),
		.boot_done(boot_done), .entry_addr(entry_addr));

	parallel_host_model u_host (.sys_clk(sys_clk), .device_ready_line(device_ready_line),
		.host_data_valid_line(host_data_valid_line), .parallel_data(parallel_data));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (mem_wr.we === 1'b1) wr_q.push_back(mem_wr);
		if (wd_clear === 1'b1) clears++;
		if (wd_disable === 1'b1) wd_on++;
	end

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic restart();
		apb(1'b1, CTRL_OFS, 32'h1);
		for (int i = 0; i < 20 && boot_done === 1'b1; i++) @(posedge sys_clk);
	endtask

	task automatic wait_done();
		for (int i = 0; i < 5000 && boot_done !== 1'b1; i++) @(posedge sys_clk);
		@(posedge sys_clk);
	endtask

	// byte mode: junk on the upper lines, low byte first
	task automatic send_b(input logic [15:0] w);
		u_host.send({8'hc3, w[7:0]}, 0);
		u_host.send({8'h3c, w[15:8]}, 2);
	endtask

	// one slow 8N1 character out, then its echo back in
	task automatic ser_char(input logic [7:0] c, output logic [7:0] e);
		logic [8:0] f;
		f = {c, 1'b0};
		for (int i = 0; i < 9; i++) begin
			serial_receive_line <= f[i];
			repeat (SER_BIT) @(posedge sys_clk);
		end
		serial_receive_line <= 1'b1;
		for (int i = 0; i < 2000 && serial_transmit_line !== 1'b0; i++) @(posedge sys_clk);
		repeat (SER_BIT / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (SER_BIT) @(posedge sys_clk);
			e[i] = serial_transmit_line;
		end
	endtask

	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d} = 4'h0;
		serial_receive_line = 1'b1;
		spi_loader_done = 1'b0;
		spi_loader_entry = 32'h0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped error", 32'(err), 32'h1);
		check("unmapped data", rd, 32'h0);
		foreach (bstream[i]) send_b(bstream[i]);
		wait_done();
		check("byte entry", entry_addr, 32'h003f8000);
		check("write count", 32'(wr_q.size()), 32'h2);
		check("addr 0", wr_q[0].addr, 32'h003f9010);
		check("data 0", 32'(wr_q[0].data), 32'h1234);
		check("addr 1", wr_q[1].addr, 32'h003f9011);
		check("data 1", 32'(wr_q[1].data), 32'habcd);
		check("clear pulses", 32'(clears), 32'h1);
		apb(1'b0, STATUS_OFS, 32'h0);
		check("mode code", 32'(rd[ST_MODE_LO +: 3]), 32'(MODE_PAR));
		restart();
		foreach (wstream[i]) u_host.send(wstream[i], 1);
		wait_done();
		check("wide entry", entry_addr, 32'h003d1234);
		restart();
		send_b(16'h1111);
		wait_done();
		check("abort entry", entry_addr, FLASH_ENTRY);
		apb(1'b0, STATUS_OFS, 32'h0);
		check("abort flag", 32'(rd[ST_ABORT]), 32'h1);
		wd_on = 0;
		for (int i = 0; i < 3; i++) begin
			{mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d} <= dpins[i];
			restart();
			wait_done();
			check("direct entry", entry_addr, dent[i]);
		end
		check("watchdog untouched", 32'(wd_on), 32'h0);
		{mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d} <= 4'h6;
		restart();
		for (int i = 0; i < 100 && spi_loader_start !== 1'b1; i++) @(posedge sys_clk);
		check("memory start", 32'(spi_loader_start), 32'h1);
		repeat (5) @(posedge sys_clk);
		spi_loader_done <= 1'b1;
		spi_loader_entry <= 32'h003f8123;
		@(posedge sys_clk);
		spi_loader_done <= 1'b0;
		wait_done();
		check("memory entry", entry_addr, 32'h003f8123);
		check("clear pulses", 32'(clears), 32'h4);
		{mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d} <= 4'h3;
		reset <= 1'b1;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (15) @(posedge sys_clk);
		check("serial active", 32'(sci_cfg.active), 32'h1);
		check("char length", 32'(sci_cfg.char_len), 32'(CHAR_LEN_8));
		check("clock divide", 32'(sci_cfg.low_speed_peripheral_clock_div), 32'(LOW_SPEED_PERIPHERAL_CLOCK_DIV4));
		check("watchdog off", 32'(wd_disable), 32'h1);
		ser_char(8'h41, echo);
		check("lock echo", 32'(echo), 32'h41);
		apb(1'b0, BAUD_OFS, 32'h0);
		check("bit period", rd, 32'(SER_BIT));
		ser_char(8'haa, echo);
		check("char echo", 32'(echo), 32'haa);
		tally_and_finish();
	end

	initial begin
		#1000000;
		failures++;
		tally_and_finish();
	end

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
endmodule

bind boot_mode_select_loader boot_loader_properties u_props (.sys_clk(sys_clk), .reset(reset),
	.mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .mode_pin_c(mode_pin_c), .mode_pin_d(mode_pin_d),
	.spi_loader_start(spi_loader_start), .wd_disable(wd_disable), .wd_clear(wd_clear), .boot_done(boot_done),
	.entry_addr(entry_addr), .sci_cfg(sci_cfg), .device_ready_line(device_ready_line),
	.host_data_valid_line(host_data_valid_line));

//--- verif/parallel_host_model.sv
// Purpose: host side of the parallel load handshake
// Assumes: ready and valid are active low
// Notes:   released data lines show the inverted last value
`timescale 1ns/100ps
module parallel_host_model (
	// clock
	input  wire logic        sys_clk,
	// handshake and data
	input  wire logic        device_ready_line,
	output logic             host_data_valid_line,
	output logic [15:0]      parallel_data
);
	initial begin
		host_data_valid_line = 1'b1;
		parallel_data = 16'hffff;
	end

	// gap stretches each host step to act as a slow host
	task automatic send(input logic [15:0] v, input int gap);
		for (int i = 0; i < 4000 && device_ready_line !== 1'b0; i++) @(posedge sys_clk);
		repeat (gap) @(posedge sys_clk);
		parallel_data <= v;
		@(posedge sys_clk);
		host_data_valid_line <= 1'b0;
		for (int i = 0; i < 4000 && device_ready_line !== 1'b1; i++) @(posedge sys_clk);
		repeat (gap) @(posedge sys_clk);
		host_data_valid_line <= 1'b1;
		@(posedge sys_clk);
		parallel_data <= ~v;
	endtask
endmodule

//--- verilog/boot_loader_pkg.sv
// Purpose: shared constants and types of the boot mode select loader
// Assumes: 50 MHz sys_clk, APB register access with 32-bit data
// Notes:   entry addresses, key words and stream framing values
package boot_loader_pkg;

	// entry addresses returned by mode selection
	localparam logic [31:0] FLASH_ENTRY    = 32'h003f7ff6;
	localparam logic [31:0] RAM_ENTRY      = 32'h003f8000;
	localparam logic [31:0] OTP_ENTRY      = 32'h003d7800;

	// stream framing
	localparam logic [15:0] KEY_WIDE       = 16'h10aa;
	localparam logic [15:0] KEY_BYTE       = 16'h08aa;
	localparam logic [15:0] END_SIZE       = 16'h0000;
	localparam logic [3:0]  RSV_LAST       = 4'h7;

	// last settle count; pins settle 8 cycles after reset before sampling
	localparam logic [3:0]  SETTLE_LAST    = 4'h7;

	// shortest start-bit width accepted as an autobaud lock
	localparam int          MIN_BIT_CYC    = 8;

	// register map
	localparam int          ADDR_W         = 8;
	localparam logic [7:0]  CTRL_OFS       = 8'h00;
	localparam logic [7:0]  STATUS_OFS     = 8'h04;
	localparam logic [7:0]  ENTRY_OFS      = 8'h08;
	localparam logic [7:0]  WORDS_OFS      = 8'h0c;
	localparam logic [7:0]  BAUD_OFS       = 8'h10;
	localparam int          CTRL_RESTART   = 0;
	localparam int          ST_BUSY        = 0;
	localparam int          ST_DONE        = 1;
	localparam int          ST_ABORT       = 2;
	localparam int          ST_WD_OFF      = 3;
	localparam int          ST_PINS_LO     = 4;
	localparam int          ST_MODE_LO     = 8;
	localparam int          ST_LOCKED      = 11;

	// serial port setup values
	localparam logic [2:0]  CHAR_LEN_8     = 3'h7;
	localparam logic [2:0]  LOW_SPEED_PERIPHERAL_CLOCK_DIV4    = 3'h2;

	typedef enum logic [5:0] {
		M_SETTLE = 6'h01,
		M_DECIDE = 6'h02,
		M_EXT    = 6'h04,
		M_STREAM = 6'h08,
		M_FINISH = 6'h10,
		M_DONE   = 6'h20
	} main_st_t;

	typedef enum logic [8:0] {
		P_KEY      = 9'h001,
		P_KEY2     = 9'h002,
		P_RSV      = 9'h004,
		P_ENTRY_HI = 9'h008,
		P_ENTRY_LO = 9'h010,
		P_SIZE     = 9'h020,
		P_DEST_HI  = 9'h040,
		P_DEST_LO  = 9'h080,
		P_DATA     = 9'h100
	} parse_st_t;

	typedef enum logic [5:0] {
		R_LOCK_IDLE = 6'h01,
		R_LOCK_MEAS = 6'h02,
		R_IDLE      = 6'h04,
		R_START     = 6'h08,
		R_BITS      = 6'h10,
		R_STOP      = 6'h20
	} rx_st_t;

	typedef enum logic [2:0] {
		H_IDLE      = 3'h1,
		H_WAIT_LOW  = 3'h2,
		H_WAIT_HIGH = 3'h4
	} par_st_t;

	typedef enum logic [2:0] {
		MODE_FLASH = 3'h0,
		MODE_SPI   = 3'h1,
		MODE_SCI   = 3'h2,
		MODE_RAM   = 3'h3,
		MODE_OTP   = 3'h4,
		MODE_PAR   = 3'h5
	} mode_t;

	typedef struct packed {
		logic       two_stop;
		logic [2:0] char_len;
		logic       parity_en;
		logic       int_clk;
		logic       loopback;
		logic       rx_irq_en;
		logic       tx_irq_en;
		logic       fifo_en;
		logic [2:0] low_speed_peripheral_clock_div;
		logic       active;
	} sci_cfg_t;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [15:0] data;
	} mem_wr_t;

endpackage

//--- verilog/boot_mode_select_loader.sv
// Purpose: boot mode selection with serial and parallel stream loaders
// Assumes: all pin inputs synchronous to sys_clk; serial-memory loader is external
// Notes:   Contract
// Contract
// - pin A high returns flash entry
// - A low, B high starts serial-memory loader
// - A,B low, C,D high starts serial loader
// - only C high returns RAM entry
// - only D high returns OTP entry
// - all pins low start parallel loader
// - watchdog off before loaders, untouched otherwise
// - after loader, watchdog on and timer cleared
// - serial loader takes byte stream only
// - autobaud lock, then echo every character
// - serial port fixed 8N1 setup, clock /4
// - skip 8 reserved words, read entry address
// - size word, zero ends, else destination, data
// - byte mode uses low eight data lines
// - first byte low, second byte high
// - ready low before each parallel transfer
// - on valid low read, then ready high
// - wait valid high before ready low again
// - key 0x10AA wide, 0x08AA byte, else abort
`timescale 1ns/100ps
module boot_mode_select_loader
	import boot_loader_pkg::*;
#(
	parameter int BIT_CNT_W = 20
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// mode pins
	input  wire logic                 mode_pin_a,
	input  wire logic                 mode_pin_b,
	input  wire logic                 mode_pin_c,
	input  wire logic                 mode_pin_d,
	// async serial port
	input  wire logic                 serial_receive_line,
	output logic                      serial_transmit_line,
	output sci_cfg_t                  sci_cfg,
	// parallel port
	input  wire logic [15:0]          parallel_data,
	input  wire logic                 host_data_valid_line,
	output logic                      device_ready_line,
	// external serial-memory loader
	output logic                      spi_loader_start,
	input  wire logic                 spi_loader_done,
	input  wire logic [31:0]          spi_loader_entry,
	// memory write port
	output mem_wr_t                   mem_wr,
	// watchdog and result
	output logic                      wd_disable,
	output logic                      wd_clear,
	output logic                      boot_done,
	output logic [31:0]               entry_addr
);

	initial begin
		if (BIT_CNT_W < 8 || BIT_CNT_W > 30) begin
			$error("BIT_CNT_W out of range");
		end
	end

	typedef struct packed {
		main_st_t             main;
		parse_st_t            ps;
		rx_st_t               rx;
		par_st_t              par;
		mode_t                mode;
		logic [3:0]           pins;
		logic [3:0]           cnt;
		logic                 src_par;
		logic                 byte_mode;
		logic                 half;
		logic [7:0]           lsb;
		logic [15:0]          pval;
		logic                 pval_ok;
		logic [15:0]          addr_hi;
		logic [31:0]          entry;
		logic [31:0]          dest;
		logic [15:0]          remain;
		logic [31:0]          words;
		logic                 aborted;
		logic [BIT_CNT_W-1:0] bit_cyc;
		logic [BIT_CNT_W-1:0] rx_tmr;
		logic [2:0]           rx_bit;
		logic [7:0]           rx_sh;
		logic                 locking;
		logic                 locked;
		logic                 echo_req;
		logic [7:0]           echo_byte;
		logic                 tx_busy;
		logic [BIT_CNT_W-1:0] tx_tmr;
		logic [9:0]           tx_sh;
		logic [3:0]           tx_cnt;
		logic                 tx_line;
		logic                 ready_line;
		sci_cfg_t             cfg;
		mem_wr_t              mem;
		logic                 wd_off;
		logic                 wd_clr;
		logic                 spi_go;
		logic                 done;
		logic [31:0]          rdata;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	logic                 apb_hit;
	logic                 restart_wr;
	logic                 word_ok;
	logic [15:0]          word;
	logic [31:0]          rd_mux;
	logic [BIT_CNT_W-1:0] one_cnt;

	assign one_cnt = {{(BIT_CNT_W-1){1'b0}}, 1'b1};

	always_comb begin
		apb_hit = 1'b1;
		rd_mux  = 32'h0000_0000;
		if (paddr == CTRL_OFS) begin
			rd_mux = 32'h0000_0000;
		end else if (paddr == STATUS_OFS) begin
			rd_mux[ST_BUSY]                = ~s_r.done;
			rd_mux[ST_DONE]                = s_r.done;
			rd_mux[ST_ABORT]               = s_r.aborted;
			rd_mux[ST_WD_OFF]              = s_r.wd_off;
			rd_mux[ST_PINS_LO+3:ST_PINS_LO] = s_r.pins;
			rd_mux[ST_MODE_LO+2:ST_MODE_LO] = s_r.mode;
			rd_mux[ST_LOCKED]              = s_r.locked;
		end else if (paddr == ENTRY_OFS) begin
			rd_mux = s_r.entry;
		end else if (paddr == WORDS_OFS) begin
			rd_mux = s_r.words;
		end else if (paddr == BAUD_OFS) begin
			rd_mux = 32'(s_r.bit_cyc);
		end else begin
			apb_hit = 1'b0;
		end
	end

	assign restart_wr = psel & penable & pwrite & apb_hit & (paddr == CTRL_OFS) & pwdata[CTRL_RESTART];

	// assemble a stream word from one wide value or two byte values
	always_comb begin
		word_ok = 1'b0;
		word    = s_r.pval;
		if (s_r.pval_ok) begin
			if (!s_r.byte_mode) begin
				word_ok = 1'b1;
			end else if (s_r.half) begin
				word_ok = 1'b1;
				word    = {s_r.pval[7:0], s_r.lsb};
			end
		end
	end

	always_comb begin
		s_nxt          = s_r;
		s_nxt.pval_ok  = 1'b0;
		s_nxt.echo_req = 1'b0;
		s_nxt.mem.we   = 1'b0;
		s_nxt.wd_clr   = 1'b0;
		s_nxt.spi_go   = 1'b0;
		if (psel && !penable) begin
			s_nxt.rdata = rd_mux;
		end

		case (s_r.main)
			M_SETTLE: begin
				s_nxt.cnt = s_r.cnt + 4'h1;
				if (s_r.cnt == SETTLE_LAST) begin
					s_nxt.main = M_DECIDE;
				end
			end
			M_DECIDE: begin
				s_nxt.pins      = {mode_pin_a, mode_pin_b, mode_pin_c, mode_pin_d};
				s_nxt.ps        = P_KEY;
				s_nxt.half      = 1'b0;
				s_nxt.byte_mode = 1'b0;
				s_nxt.words     = 32'h0000_0000;
				s_nxt.aborted   = 1'b0;
				s_nxt.main      = M_DONE;
				if (mode_pin_a) begin
					s_nxt.mode  = MODE_FLASH;
					s_nxt.entry = FLASH_ENTRY;
				end else if (mode_pin_b) begin
					s_nxt.mode   = MODE_SPI;
					s_nxt.spi_go = 1'b1;
					s_nxt.wd_off = 1'b1;
					s_nxt.main   = M_EXT;
				end else if (mode_pin_c && mode_pin_d) begin
					s_nxt.mode    = MODE_SCI;
					s_nxt.src_par = 1'b0;
					s_nxt.wd_off  = 1'b1;
					s_nxt.rx      = R_LOCK_IDLE;
					s_nxt.locked  = 1'b0;
					s_nxt.main    = M_STREAM;
					s_nxt.cfg     = '{two_stop: 1'b0, char_len: CHAR_LEN_8, parity_en: 1'b0, int_clk: 1'b1,
						loopback: 1'b0, rx_irq_en: 1'b0, tx_irq_en: 1'b0, fifo_en: 1'b0,
						low_speed_peripheral_clock_div: LOW_SPEED_PERIPHERAL_CLOCK_DIV4, active: 1'b1};
				end else if (mode_pin_c) begin
					s_nxt.mode  = MODE_RAM;
					s_nxt.entry = RAM_ENTRY;
				end else if (mode_pin_d) begin
					s_nxt.mode  = MODE_OTP;
					s_nxt.entry = OTP_ENTRY;
				end else begin
					s_nxt.mode    = MODE_PAR;
					s_nxt.src_par = 1'b1;
					s_nxt.wd_off  = 1'b1;
					s_nxt.par     = H_IDLE;
					s_nxt.main    = M_STREAM;
				end
			end
			M_EXT: begin
				if (spi_loader_done) begin
					s_nxt.entry = spi_loader_entry;
					s_nxt.main  = M_FINISH;
				end
			end
			M_STREAM: begin
				if (s_r.pval_ok && s_r.byte_mode && !s_r.half) begin
					s_nxt.lsb  = s_r.pval[7:0];
					s_nxt.half = 1'b1;
				end else if (word_ok) begin
					s_nxt.half = 1'b0;
				end
				case (s_r.ps)
					P_KEY: begin
						if (s_r.pval_ok) begin
							if (s_r.pval == KEY_WIDE) begin
								s_nxt.ps = P_RSV;
								s_nxt.cnt = 4'h0;
								if (!s_r.src_par) begin
									s_nxt.entry   = FLASH_ENTRY;
									s_nxt.aborted = 1'b1;
									s_nxt.main    = M_FINISH;
								end
							end else begin
								s_nxt.lsb = s_r.pval[7:0];
								s_nxt.ps  = P_KEY2;
							end
						end
					end
					P_KEY2: begin
						if (s_r.pval_ok) begin
							if ({s_r.pval[7:0], s_r.lsb} == KEY_BYTE) begin
								s_nxt.byte_mode = 1'b1;
								s_nxt.cnt       = 4'h0;
								s_nxt.ps        = P_RSV;
							end else begin
								s_nxt.entry   = FLASH_ENTRY;
								s_nxt.aborted = 1'b1;
								s_nxt.main    = M_FINISH;
							end
						end
					end
					P_RSV: begin
						if (word_ok) begin
							s_nxt.cnt = s_r.cnt + 4'h1;
							if (s_r.cnt == RSV_LAST) begin
								s_nxt.ps = P_ENTRY_HI;
							end
						end
					end
					P_ENTRY_HI: begin
						if (word_ok) begin
							s_nxt.addr_hi = word;
							s_nxt.ps      = P_ENTRY_LO;
						end
					end
					P_ENTRY_LO: begin
						if (word_ok) begin
							s_nxt.entry = {s_r.addr_hi, word};
							s_nxt.ps    = P_SIZE;
						end
					end
					P_SIZE: begin
						if (word_ok) begin
							s_nxt.remain = word;
							if (word == END_SIZE) begin
								s_nxt.main = M_FINISH;
							end else begin
								s_nxt.ps = P_DEST_HI;
							end
						end
					end
					P_DEST_HI: begin
						if (word_ok) begin
							s_nxt.addr_hi = word;
							s_nxt.ps      = P_DEST_LO;
						end
					end
					P_DEST_LO: begin
						if (word_ok) begin
							s_nxt.dest = {s_r.addr_hi, word};
							s_nxt.ps   = P_DATA;
						end
					end
					P_DATA: begin
						if (word_ok) begin
							s_nxt.mem.we   = 1'b1;
							s_nxt.mem.addr = s_r.dest;
							s_nxt.mem.data = word;
							s_nxt.dest     = s_r.dest + 32'h0000_0001;
							s_nxt.words    = s_r.words + 32'h0000_0001;
							s_nxt.remain   = s_r.remain - 16'h0001;
							if (s_r.remain == 16'h0001) begin
								s_nxt.ps = P_SIZE;
							end
						end
					end
					default: s_nxt.ps = P_KEY;
				endcase
			end
			M_FINISH: begin
				s_nxt.wd_off     = 1'b0;
				s_nxt.wd_clr     = 1'b1;
				s_nxt.cfg.active = 1'b0;
				s_nxt.ready_line = 1'b1;
				s_nxt.main       = M_DONE;
			end
			M_DONE: begin
				s_nxt.done = 1'b1;
				if (restart_wr) begin
					s_nxt.done = 1'b0;
					s_nxt.cnt  = 4'h0;
					s_nxt.main = M_SETTLE;
				end
			end
			default: s_nxt.main = M_SETTLE;
		endcase

		// parallel handshake, ready low only while the parser wants a value
		if (s_r.main == M_STREAM && s_r.src_par) begin
			case (s_r.par)
				H_IDLE: begin
					if (!s_r.pval_ok) begin
						s_nxt.ready_line = 1'b0;
						s_nxt.par        = H_WAIT_LOW;
					end
				end
				H_WAIT_LOW: begin
					if (!host_data_valid_line) begin
						s_nxt.pval       = parallel_data;
						s_nxt.pval_ok    = 1'b1;
						s_nxt.ready_line = 1'b1;
						s_nxt.par        = H_WAIT_HIGH;
					end
				end
				H_WAIT_HIGH: begin
					if (host_data_valid_line) begin
						s_nxt.par = H_IDLE;
					end
				end
				default: s_nxt.par = H_IDLE;
			endcase
		end

		// serial receiver with autobaud on the first character
		if (s_r.main == M_STREAM && !s_r.src_par) begin
			case (s_r.rx)
				R_LOCK_IDLE: begin
					if (!serial_receive_line) begin
						s_nxt.rx_tmr = one_cnt;
						s_nxt.rx     = R_LOCK_MEAS;
					end
				end
				R_LOCK_MEAS: begin
					if (!serial_receive_line) begin
						if (~&s_r.rx_tmr) begin
							s_nxt.rx_tmr = s_r.rx_tmr + one_cnt;
						end
					end else if (s_r.rx_tmr < BIT_CNT_W'(MIN_BIT_CYC)) begin
						s_nxt.rx = R_LOCK_IDLE;
					end else begin
						s_nxt.bit_cyc = s_r.rx_tmr;
						s_nxt.rx_sh   = 8'h80;
						s_nxt.rx_bit  = 3'h1;
						s_nxt.locking = 1'b1;
						s_nxt.rx_tmr  = s_r.rx_tmr + (s_r.rx_tmr >> 1) - one_cnt;
						s_nxt.rx      = R_BITS;
					end
				end
				R_IDLE: begin
					if (!serial_receive_line) begin
						s_nxt.rx_tmr = (s_r.bit_cyc >> 1) - one_cnt;
						s_nxt.rx     = R_START;
					end
				end
				R_START: begin
					s_nxt.rx_tmr = s_r.rx_tmr - one_cnt;
					if (s_r.rx_tmr == '0) begin
						s_nxt.rx_tmr = s_r.bit_cyc - one_cnt;
						s_nxt.rx_bit = 3'h0;
						s_nxt.rx     = serial_receive_line ? R_IDLE : R_BITS;
					end
				end
				R_BITS: begin
					s_nxt.rx_tmr = s_r.rx_tmr - one_cnt;
					if (s_r.rx_tmr == '0) begin
						s_nxt.rx_sh  = {serial_receive_line, s_r.rx_sh[7:1]};
						s_nxt.rx_tmr = s_r.bit_cyc - one_cnt;
						s_nxt.rx_bit = s_r.rx_bit + 3'h1;
						if (s_r.rx_bit == 3'h7) begin
							s_nxt.rx = R_STOP;
						end
					end
				end
				R_STOP: begin
					s_nxt.rx_tmr = s_r.rx_tmr - one_cnt;
					if (s_r.rx_tmr == '0) begin
						s_nxt.echo_req  = 1'b1;
						s_nxt.echo_byte = s_r.rx_sh;
						s_nxt.locking   = 1'b0;
						s_nxt.locked    = 1'b1;
						s_nxt.pval      = {8'h00, s_r.rx_sh};
						s_nxt.pval_ok   = ~s_r.locking;
						s_nxt.rx        = R_IDLE;
					end
				end
				default: s_nxt.rx = R_LOCK_IDLE;
			endcase
		end

		// echo transmitter: start, eight data bits lsb first, one stop
		if (!s_r.tx_busy) begin
			s_nxt.tx_line = 1'b1;
			if (s_r.echo_req) begin
				s_nxt.tx_sh   = {1'b1, s_r.echo_byte, 1'b0};
				s_nxt.tx_line = 1'b0;
				s_nxt.tx_cnt  = 4'h0;
				s_nxt.tx_tmr  = s_r.bit_cyc - one_cnt;
				s_nxt.tx_busy = 1'b1;
			end
		end else begin
			s_nxt.tx_tmr = s_r.tx_tmr - one_cnt;
			if (s_r.tx_tmr == '0) begin
				s_nxt.tx_tmr = s_r.bit_cyc - one_cnt;
				s_nxt.tx_sh  = {1'b1, s_r.tx_sh[9:1]};
				s_nxt.tx_line = s_r.tx_sh[1];
				s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
				if (s_r.tx_cnt == 4'h9) begin
					s_nxt.tx_busy = 1'b0;
					s_nxt.tx_line = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_r            <= '0;
			s_r.main       <= M_SETTLE;
			s_r.ps         <= P_KEY;
			s_r.rx         <= R_LOCK_IDLE;
			s_r.par        <= H_IDLE;
			s_r.mode       <= MODE_FLASH;
			s_r.entry      <= FLASH_ENTRY;
			s_r.tx_line    <= 1'b1;
			s_r.ready_line <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata               = s_r.rdata;
	assign pready               = 1'b1;
	assign pslverr              = psel & penable & ~apb_hit;
	assign serial_transmit_line = s_r.tx_line;
	assign sci_cfg              = s_r.cfg;
	assign device_ready_line    = s_r.ready_line;
	assign spi_loader_start     = s_r.spi_go;
	assign mem_wr               = s_r.mem;
	assign wd_disable           = s_r.wd_off;
	assign wd_clear             = s_r.wd_clr;
	assign boot_done            = s_r.done;
	assign entry_addr           = s_r.entry;

endmodule
